/* File: adcp_pkg.sv */
// Package of constants and carrier types for the result byte port
package adcp_pkg;

  // Result layout
  localparam int MAG_W          = 12;
  localparam int RES_W          = 14;
  localparam int LO_W           = 8;
  localparam int HI_W           = 6;
  localparam int FULL_SCALE     = 4096;
  localparam int POL_BIT        = 12;
  localparam int OVR_BIT        = 13;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STAT   = 8'h04;
  localparam logic [7:0] ADDR_IRQ    = 8'h08;
  localparam logic [7:0] ADDR_MASK   = 8'h0c;
  localparam logic [7:0] ADDR_SAMPLE = 8'h10;
  localparam logic [7:0] ADDR_RESULT = 8'h14;

  // Control field positions
  localparam int CTRL_RUN  = 0;
  localparam int CTRL_MODE = 1;

  // Interrupt bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_XFER = 1;
  localparam int IRQ_DROP = 2;
  localparam int IRQ_W    = 3;

  // Reset values
  localparam logic [1:0]       CTRL_RST = 2'h0;
  localparam logic [IRQ_W-1:0] MASK_RST = 3'h0;

  // Conversion timing in internal clock cycles
  localparam int CONV_CYCLES = 64;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Handshake states, one-hot
  typedef enum logic [3:0] {
    HS_IDLE = 4'h1,
    HS_HIGH = 4'h2,
    HS_LOW  = 4'h4,
    HS_DONE = 4'h8
  } adcp_hs_type;

  // Result word
  typedef struct packed {
    logic             ovr;
    logic             pol;
    logic [MAG_W-1:0] mag;
  } adcp_result_type;

  // Pin bundle toward the data lines
  typedef struct packed {
    logic [RES_W-1:0] data_o;
    logic [RES_W-1:0] data_oe;
  } adcp_pins_type;

  // All state of the port
  typedef struct packed {
    adcp_hs_type      hs;
    adcp_result_type  latched;
    logic [15:0]      conv_cnt;
    logic             busy;
    logic             status;
    logic             mode_d;
    logic             trig;
    logic             load_n;
    logic             hi_en;
    logic             lo_en;
    logic [1:0]       ctrl;
    logic [IRQ_W-1:0] irq;
    logic [IRQ_W-1:0] mask;
    logic [MAG_W:0]   sample;
    logic             aw_ok;
    logic             w_ok;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             send_lo;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [1:0]       sync_ce;
    logic [1:0]       sync_hb;
    logic [1:0]       sync_lb;
    logic [1:0]       sync_send;
  } adcp_state_type;

endpackage

/* File: adcp_port.sv */
// Result byte output port of a dual-slope converter, with AXI4-Lite control
// Behaviour
// - Input twice reference gives 4096 counts
// - Load low: each byte by own enable
// - Load acts as master enable directly
// - Both enables drive all 14 outputs
// - Undriven outputs released for shared bus
// - Status falls when new result ready
// - Run/hold register bit starts conversions
// - Handshake load strobe rises to latch
// - Byte enables become byte flag outputs
// - Send high strobes next byte out
// - Send low holds byte and position
// - Send returns high, advance sequence
// - Mode high sends every result
// - Mode rising edge starts single sequence
// - High byte first, low enable ends
// - Result during handshake is discarded
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
module adcp_port
  import adcp_pkg::*;
#(
  parameter int CONV_LEN = adcp_pkg::CONV_CYCLES
)(
  // Clock, reset, enable
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  input  wire logic                      clk_en,
  // AXI4-Lite write address
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [7:0]                s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  // AXI4-Lite write response
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [7:0]                s_axi_araddr,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  // Converter pins
  input  wire logic                      load_n_i,
  output logic                           load_n_o,
  output logic                           load_n_oe,
  input  wire logic                      high_byte_enable_n_i,
  output logic                           high_byte_enable_n_o,
  output logic                           high_byte_enable_n_oe,
  input  wire logic                      low_byte_enable_n_i,
  output logic                           low_byte_enable_n_o,
  output logic                           low_byte_enable_n_oe,
  input  wire logic                      send_i,
  output adcp_pkg::adcp_pins_type        data_pins,
  output logic                           status_o,
  // Interrupt
  output logic                           irq_o
);

  // Elaboration check
  if (CONV_LEN < 4 || CONV_LEN > 65535)
  begin : g_bad_len
    $error("CONV_LEN out of range");
  end

  adcp_state_type s_r;
  adcp_state_type s_nxt;

  // Byte layout of a result
  function automatic logic [RES_W-1:0] pack_res(input adcp_result_type r);
    pack_res = {r.ovr, r.pol, r.mag};
  endfunction

  // Map a sign-magnitude count to a result, magnitude passed through unchanged
  function automatic adcp_result_type scale(input logic [MAG_W:0] smp);
    adcp_result_type r;
    r.pol = smp[MAG_W];
    r.mag = smp[MAG_W-1:0];
    r.ovr = (smp[MAG_W-1:0] == 12'hfff);        // Top code flags overrange
    scale = r;
  endfunction

  logic hs_mode;
  logic run;
  logic aw_go;
  logic ar_go;
  logic w_go;
  logic [RES_W-1:0] word;
  logic conv_end;

  assign hs_mode = s_r.ctrl[CTRL_MODE];
  assign run     = s_r.ctrl[CTRL_RUN];
  assign word    = pack_res(s_r.latched);
  assign conv_end = s_r.busy && (s_r.conv_cnt == 16'(CONV_LEN - 1));

  // Handshake outputs may be combinational
  assign s_axi_awready = !s_r.aw_ok && !s_r.bvalid;
  assign s_axi_wready  = !s_r.w_ok && !s_r.bvalid;
  assign s_axi_arready = !s_r.rvalid;
  assign aw_go = s_axi_awvalid && s_axi_awready;
  assign w_go  = s_axi_wvalid && s_axi_wready;
  assign ar_go = s_axi_arvalid && s_axi_arready;

  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp  = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata  = s_r.rdata;
  assign s_axi_rresp  = s_r.rresp;
  assign status_o     = s_r.status;
  assign irq_o        = |(s_r.irq & s_r.mask);

  // Pin direction: control pins are outputs only in handshake mode
  assign load_n_o             = s_r.load_n;
  assign load_n_oe            = hs_mode;
  assign high_byte_enable_n_o = !s_r.hi_en;
  assign high_byte_enable_n_oe = hs_mode;
  assign low_byte_enable_n_o  = !s_r.lo_en;
  assign low_byte_enable_n_oe = hs_mode;

  // Data lines: enables from the sequencer in handshake mode, else decoded from synchronised pins
  always_comb
  begin
    logic hi_on;
    logic lo_on;
    hi_on = 1'b0;
    lo_on = 1'b0;
    if (hs_mode)
    begin
      hi_on = s_r.hi_en;
      lo_on = s_r.lo_en;
    end
    else
    begin
      // Load is master; low load leaves each byte to its enable
      hi_on = !s_r.sync_ce[1] && !s_r.sync_hb[1];
      lo_on = !s_r.sync_ce[1] && !s_r.sync_lb[1];  // Both on: all 14 lines
    end
    data_pins.data_o  = word;
    data_pins.data_oe = {{HI_W{hi_on}}, {LO_W{lo_on}}};  // Off lines released
  end

  // Next-state logic
  always_comb
  begin
    logic send;
    logic [31:0] rd;
    logic        wr_mapped;
    logic        rd_mapped;
    logic [IRQ_W-1:0] ev;
    s_nxt = s_r;
    ev    = '0;
    rd    = 32'h0;
    rd_mapped = 1'b1;
    wr_mapped = 1'b1;

    // Two-flop synchronisers on pins
    s_nxt.sync_ce   = {s_r.sync_ce[0], load_n_i};
    s_nxt.sync_hb   = {s_r.sync_hb[0], high_byte_enable_n_i};
    s_nxt.sync_lb   = {s_r.sync_lb[0], low_byte_enable_n_i};
    s_nxt.sync_send = {s_r.sync_send[0], send_i};
    // Direct mode needs nothing from the host on send; it is ignored there
    send = s_r.sync_send[1];

    // Conversion sequencer under run/hold
    s_nxt.status = s_r.busy;
    if (!s_r.busy)
    begin
      if (run)
      begin
        s_nxt.busy     = 1'b1;
        s_nxt.conv_cnt = 16'h0;
      end
    end
    else if (conv_end)
    begin
      s_nxt.busy = 1'b0;
      if (s_r.hs == HS_IDLE)
      begin
        s_nxt.latched = scale(s_r.sample);
        ev[IRQ_DONE]  = 1'b1;                       // Status drops on the edge after next
        if (hs_mode)
          s_nxt.trig = 1'b1;                        // Every result sent
      end
      else
        ev[IRQ_DROP] = 1'b1;                        // Result lost mid-handshake
    end
    else
      s_nxt.conv_cnt = s_r.conv_cnt + 16'h1;

    // Mode rising edge requests one sequence
    s_nxt.mode_d = hs_mode;
    if (hs_mode && !s_r.mode_d)
      s_nxt.trig = 1'b1;

    // Handshake byte sequencer
    // Each byte waits for send to drop and then return, so a slow receiver
    // never misses a strobe; one flag remembers that the low phase was seen
    s_nxt.load_n = 1'b1;
    case (s_r.hs)
      HS_IDLE:
      begin
        s_nxt.hi_en   = 1'b0;
        s_nxt.lo_en   = 1'b0;
        s_nxt.send_lo = 1'b0;
        if (s_r.trig && hs_mode)
        begin
          s_nxt.trig  = 1'b0;
          s_nxt.hs    = HS_HIGH;                    // High byte first
          s_nxt.hi_en = 1'b1;
        end
      end
      HS_HIGH:
      begin
        // Receiver must finish before next result
        if (send)
        begin
          s_nxt.load_n  = 1'b0;                     // Rises next cycle to latch
          s_nxt.send_lo = 1'b0;
          s_nxt.hs      = HS_LOW;
        end
      end
      HS_LOW:
      begin
        if (s_r.hi_en)
        begin
          if (!send)
          begin
            // Receiver busy: keep byte driven, hold place
            s_nxt.send_lo = 1'b1;
          end
          else if (s_r.send_lo)
          begin
            // Byte taken and send back high: advance
            s_nxt.hi_en   = 1'b0;
            s_nxt.lo_en   = 1'b1;
            s_nxt.send_lo = 1'b0;
          end
        end
        else if (s_r.lo_en && send && s_r.load_n)
        begin
          s_nxt.load_n = 1'b0;
          s_nxt.hs     = HS_DONE;
        end
      end
      HS_DONE:
      begin
        if (!send)
        begin
          s_nxt.send_lo = 1'b1;
        end
        else if (s_r.send_lo && s_r.load_n)
        begin
          s_nxt.lo_en   = 1'b0;                     // Low enable returns high
          s_nxt.send_lo = 1'b0;
          s_nxt.hs      = HS_IDLE;
          ev[IRQ_XFER]  = 1'b1;
        end
      end
      default:
      begin
        s_nxt.hs    = HS_IDLE;
        s_nxt.hi_en = 1'b0;
        s_nxt.lo_en = 1'b0;
      end
    endcase

    // Mode dropped mid-sequence: abandon it, else it would wait forever
    // for a receiver that no longer sees the strobes
    if (!hs_mode && s_r.hs != HS_IDLE)
    begin
      s_nxt.hs      = HS_IDLE;
      s_nxt.hi_en   = 1'b0;
      s_nxt.lo_en   = 1'b0;
      s_nxt.send_lo = 1'b0;
    end

    // AXI write channel capture
    if (aw_go)
    begin
      s_nxt.aw_ok  = 1'b1;
      s_nxt.awaddr = s_axi_awaddr;
    end
    if (w_go)
    begin
      s_nxt.w_ok  = 1'b1;
      s_nxt.wdata = s_axi_wdata;
      s_nxt.wstrb = s_axi_wstrb;                    // Strobe is gone by commit time
    end
    if (s_r.aw_ok && s_r.w_ok)
    begin
      s_nxt.aw_ok  = 1'b0;
      s_nxt.w_ok   = 1'b0;
      s_nxt.bvalid = 1'b1;
      case (s_r.awaddr)
        ADDR_CTRL:
        begin
          if (s_r.wstrb[0])
            s_nxt.ctrl = s_r.wdata[1:0];
        end
        ADDR_IRQ:
        begin
          if (s_r.wstrb[0])
            s_nxt.irq = s_r.irq & ~s_r.wdata[IRQ_W-1:0];
        end
        ADDR_MASK:
        begin
          if (s_r.wstrb[0])
            s_nxt.mask = s_r.wdata[IRQ_W-1:0];
        end
        ADDR_SAMPLE: s_nxt.sample = s_r.wdata[MAG_W:0];
        default:     wr_mapped = 1'b0;
      endcase
      s_nxt.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_r.bvalid && s_axi_bready)
      s_nxt.bvalid = 1'b0;

    // Events set after clear so a same-cycle event wins
    s_nxt.irq = s_nxt.irq | ev;

    // AXI read channel
    if (ar_go)
    begin
      case (s_axi_araddr)
        ADDR_CTRL:   rd = {30'h0, s_r.ctrl};
        ADDR_STAT:   rd = {27'h0, s_r.hs, s_r.status};
        ADDR_IRQ:    rd = {29'h0, s_r.irq};
        ADDR_MASK:   rd = {29'h0, s_r.mask};
        ADDR_SAMPLE: rd = {19'h0, s_r.sample};
        ADDR_RESULT: rd = {18'h0, word};
        default:     rd_mapped = 1'b0;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rd;
      s_nxt.rresp  = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_r.rvalid && s_axi_rready)
      s_nxt.rvalid = 1'b0;
  end

  // State register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_r           <= '0;
      s_r.hs        <= HS_IDLE;
      s_r.load_n    <= 1'b1;
      s_r.ctrl      <= CTRL_RST;
      s_r.mask      <= MASK_RST;
      s_r.sync_ce   <= 2'h3;
      s_r.sync_hb   <= 2'h3;
      s_r.sync_lb   <= 2'h3;
      s_r.sync_send <= 2'h3;
    end
    else if (clk_en)
      s_r <= s_nxt;
  end

endmodule // adcp_port

/* File: adcp_port_asserts.sv */
// Concurrent checks on the result byte port pins
`timescale 1ns/10ps
module adcp_port_asserts
  import adcp_pkg::*;
(
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Read handshake
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  // Converter pins
  input wire logic                    load_n_o,
  input wire logic                    load_n_oe,
  input wire logic                    high_byte_enable_n_o,
  input wire logic                    high_byte_enable_n_oe,
  input wire logic                    low_byte_enable_n_o,
  input wire logic                    low_byte_enable_n_oe,
  input wire adcp_pkg::adcp_pins_type data_pins,
  input wire logic                    status_o
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Load strobe is one low cycle, then its rising edge
  sequence s_pulse;
    !load_n_o ##1 load_n_o;
  endsequence
  property p_rst; disable iff (1'b0) !aresetn |=> data_pins.data_oe == '0 && !load_n_oe;
  endproperty
  a_rst: assert property (p_rst) else $error("lines driven after reset");
  property p_whole; data_pins.data_oe[7:0] inside {8'h00, 8'hff} &&
    data_pins.data_oe[13:8] inside {6'h00, 6'h3f};
  endproperty
  a_whole: assert property (p_whole) else $error("byte partly driven");
  property p_dir; load_n_oe == high_byte_enable_n_oe && load_n_oe == low_byte_enable_n_oe;
  endproperty
  a_dir: assert property (p_dir) else $error("pin directions differ");
  property p_one; load_n_oe |-> high_byte_enable_n_o || low_byte_enable_n_o;
  endproperty
  a_one: assert property (p_one) else $error("both byte flags low");
  property p_pulse; load_n_oe && $fell(load_n_o) |-> s_pulse;
  endproperty
  a_pulse: assert property (p_pulse) else $error("load strobe too long");
  property p_strb; !load_n_o |-> !high_byte_enable_n_o || !low_byte_enable_n_o;
  endproperty
  a_strb: assert property (p_strb) else $error("strobe without byte");
  property p_status; $rose(status_o) |-> status_o [*8];
  endproperty
  a_status: assert property (p_status) else $error("conversion cut short");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
endmodule // adcp_port_asserts

bind adcp_port adcp_port_asserts chk_u (.*);

/* File: adcp_rx_model.sv */
// Far-side receiver model for the handshake byte sequence
`timescale 1ns/10ps
module adcp_rx_model
  import adcp_pkg::*;
(
  // Clock and mode
  input  wire logic                      aclk,
  input  wire logic                      hs,
  // Wire levels
  input  wire logic                      load_n,
  input  wire logic                      hi_n,
  input  wire logic                      lo_n,
  input  wire logic [adcp_pkg::RES_W-1:0] data,
  input  wire logic [7:0]                stall,
  // Receiver side
  output logic                           send,
  output logic [adcp_pkg::RES_W-1:0]     word,
  output logic                           got
);
  int wait_c = 0;
  initial send = 1'b1; // Held high when idle and in direct mode
  initial got = 1'b0;
  // Take the byte during its strobe, then stay busy for the stall
  always @(posedge aclk)
  begin
    got <= 1'b0;
    if (hs && !load_n && send)
    begin
      if (!hi_n)
        word[13:8] <= data[13:8];
      if (!lo_n)
        word[7:0] <= data[7:0];
      got <= !lo_n;
      send <= 1'b0;
      wait_c <= stall;
    end
    else if (wait_c > 1)
      wait_c <= wait_c - 1;
    else
      send <= 1'b1;
  end
endmodule // adcp_rx_model

/* File: tb_adc_result_byte_output_port.sv */
// Self-checking bench for the result byte port
`timescale 1ns/10ps
module tb_adc_result_byte_output_port;
  import adcp_pkg::*;
  localparam int CL = 64;
  logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, stall = 8'h01;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd_d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
  logic load_n_o, load_n_oe, high_byte_enable_n_o, high_byte_enable_n_oe;
  logic low_byte_enable_n_o, low_byte_enable_n_oe, send_i, status_o, irq_o, got;
  logic ld_tb = 1'b1, hb_tb = 1'b1, lb_tb = 1'b1;
  logic [13:0] word, eoe;
  logic [12:0] smp;
  adcp_pins_type data_pins;
  int err_total = 0, samples_checked = 0, tmo = 0;
  logic [13:0] q[$];
  // Wire levels: undriven data lines show the inverse of the output word, undriven control lines the bench levels
  wire logic load_n_i = load_n_oe ? load_n_o : ld_tb;
  wire logic high_byte_enable_n_i = high_byte_enable_n_oe ? high_byte_enable_n_o : hb_tb;
  wire logic low_byte_enable_n_i = low_byte_enable_n_oe ? low_byte_enable_n_o : lb_tb;
  wire logic [13:0] dbus = data_pins.data_o ~^ data_pins.data_oe;

  adcp_port #(.CONV_LEN(CL)) dut_u (.*);
  adcp_rx_model rx_u (.aclk(aclk), .hs(load_n_oe), .load_n(load_n_i),
    .hi_n(high_byte_enable_n_i), .lo_n(low_byte_enable_n_i), .data(dbus),
    .stall(stall), .send(send_i), .word(word), .got(got));

  // Clock
  always #10 aclk = ~aclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [13:0] enc(input logic [12:0] s);
    return {s[11:0] == 12'hfff, s[12], s[11:0]};
  endfunction

  // Write: both channels offered, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    while (!(aw_t && w_t))
    begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1 && !aw_t)
      begin
        aw_t = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready === 1'b1 && !w_t)
      begin
        w_t = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
  endtask

  task automatic rd(input logic [7:0] a);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rd_r = s_axi_rresp;
  endtask

  // Two finished conversions, so the latch holds the current sample
  task automatic conv2;
    wr(ADDR_MASK, 32'h1);
    repeat (2)
    begin
      wr(ADDR_IRQ, 32'h7);
      while (irq_o !== 1'b1) @(posedge aclk);
      @(posedge aclk);
      chk(status_o, 1'b0);
    end
  endtask

  // Compare each received word with the oldest note
  always @(posedge aclk)
    if (got && q.size() > 0)
      chk(word, q.pop_front());

  // Hang guard
  always @(posedge aclk)
  begin
    tmo++;
    if (tmo == 20000)
    begin
      err_total++;
      complete_run;
    end
  end

  initial
  begin
    void'($urandom(85));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(ADDR_CTRL);
    chk(rd_d, CTRL_RST);
    rd(ADDR_MASK);
    chk(rd_d, MASK_RST);
    rd(8'h20);
    chk(rd_r, RESP_SLVERR);
    repeat (2 * CL) @(posedge aclk);
    rd(ADDR_IRQ);
    chk(rd_d[0], 1'b0);
    $display("test reset done");
    // Direct mode: masked event, then every enable combination
    smp = 13'h1fff;
    wr(ADDR_SAMPLE, {19'h0, smp});
    wr(ADDR_CTRL, 32'h1);
    repeat (2 * CL) @(posedge aclk);
    chk(irq_o, 1'b0);
    conv2;
    wr(ADDR_IRQ, 32'h7);
    chk(irq_o, 1'b0);
    rd(ADDR_RESULT);
    chk(rd_d, enc(smp));
    for (int i = 0; i < 8; i++)
    begin
      {ld_tb, hb_tb, lb_tb} <= 3'(i);
      repeat (6) @(posedge aclk);
      eoe = {{6{!i[2] && !i[1]}}, {8{!i[2] && !i[0]}}};
      chk(data_pins.data_oe, eoe);
      chk(dbus & eoe, enc(smp) & eoe);
    end
    {ld_tb, hb_tb, lb_tb} <= 3'h7;
    $display("test direct done");
    // Handshake on demand, random results and stalls, last one overrun
    for (int k = 0; k < 4; k++)
    begin
      smp = 13'($urandom);
      stall <= (k == 3) ? 8'h96 : 8'(1 + $urandom % 20);
      wr(ADDR_SAMPLE, {19'h0, smp});
      wr(ADDR_CTRL, 32'h1);
      conv2;
      wr(ADDR_IRQ, 32'h7);
      q.push_back(enc(smp));
      wr(ADDR_CTRL, 32'h3);
      if (k == 3)
        wr(ADDR_SAMPLE, 32'h0);
      while (q.size() > 0) @(posedge aclk);
      repeat (200) @(posedge aclk);
      wr(ADDR_CTRL, 32'h1);
      rd(ADDR_IRQ);
      chk(rd_d[1], 1'b1);
      if (k == 3)
        chk(rd_d[2], 1'b1);
    end
    $display("test handshake done");
    complete_run;
  end
endmodule // tb_adc_result_byte_output_port
